// File: vector_pkg.sv
// Purpose: Constants for reset entry and vector table addressing.
// Assumes: 24-bit program addresses, two address units per vector slot.
// Notes:   Shared by the sequencer and the address generator.
package vector_pkg;
    localparam int          ADDR_W          = 24;
    localparam int          SLOT_W          = 7;
    localparam logic [23:0] RESET_ADDR      = 24'h000000;
    localparam logic [23:0] RESET_TGT_ADDR  = 24'h000002;
    localparam logic [23:0] TRAP_BASE       = 24'h000004;
    localparam logic [23:0] IRQ_BASE        = 24'h000014;
    localparam logic [23:0] ALT_OFFSET      = 24'h000100;
    localparam logic [23:0] CODE_START      = 24'h000200;
    localparam int          NUM_TRAPS       = 8;
    localparam int          NUM_IRQS        = 118;
    localparam int          NUM_VECTORS     = 126;
    localparam logic [6:0]  LAST_IRQ        = 7'h75;
    localparam logic [6:0]  TRAP_OSC_FAIL   = 7'h01;
    localparam logic [6:0]  TRAP_ADDR_ERR   = 7'h02;
    localparam logic [6:0]  TRAP_STACK_ERR  = 7'h03;
    localparam logic [6:0]  TRAP_MATH_ERR   = 7'h04;
endpackage : vector_pkg

// File: vector_addr_gen.sv
// Purpose: Maps a vector slot number and table select to its entry address.
// Assumes: Slot 0..7 are traps, slot 8+n is interrupt n.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module vector_addr_gen (
    // Slot selection
    input  wire logic [6:0]  slot_in,
    input  wire logic        alt_in,
    // Entry address
    output logic      [23:0] addr_out
);
    always_comb begin
        addr_out = vector_pkg::TRAP_BASE + {16'h0000, slot_in, 1'b0};
        if (alt_in) begin
            addr_out = addr_out + vector_pkg::ALT_OFFSET;
        end
    end
endmodule : vector_addr_gen

// File: reset_vector_unit.sv
// Purpose: Reset entry and vector dispatch address sequencing for the core.
//          Issues the boot fetch at the reset address, then turns trap and
//          interrupt requests into vector entry fetches and counter loads.
// Assumes: Core presents trap and interrupt requests as flag vectors.
//          Requests are levels that the core drops once dispatch is done.
// Notes:   Priority resolution among equal levels is by vector address only.
//          User priority levels live outside this block.
//          Clock enable low freezes the whole sequencer.
`timescale 1ns/1ps

module reset_vector_unit #(
    parameter int IRQ_COUNT = vector_pkg::NUM_IRQS
) (
    // Clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_b_in,
    input  wire logic                 clk_en_in,
    // Table selection
    input  wire logic                 alt_table_select_in,

    // Requests from core side logic
    input  wire logic [7:0]           trap_req_in,
    input  wire logic [IRQ_COUNT-1:0] irq_req_in,

    // Program memory fetch port
    output logic                      fetch_req_out,
    output logic      [23:0]          fetch_addr_out,
    input  wire logic                 fetch_ack_in,
    input  wire logic [23:0]          fetch_data_in,

    // Program counter load
    output logic                      pc_load_out,
    output logic      [23:0]          pc_out,

    // Dispatch status
    output logic      [6:0]           vector_num_out,
    output logic                      ready_out
);

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_RESET_FETCH,
        ST_IDLE,
        ST_VEC_FETCH
    } seq_state_type;

    typedef struct packed {
        // Sequencer position
        seq_state_type state;
        logic          boot_done;
        // Fetch port
        logic          fetch_req;
        logic [23:0]   fetch_addr;
        // Program counter side
        logic          pc_load;
        logic [23:0]   pc;
        logic [6:0]    vector_num;
        logic          ready;
    } state_type;

    // ************************************************************
    // Local sizes and nets
    // ************************************************************
    // Bit index of the flat request word equals the slot number
    localparam int NUM_SRC = vector_pkg::NUM_TRAPS + IRQ_COUNT;

    state_type          s_reg;
    state_type          s_next;

    // Priority chain
    logic [NUM_SRC-1:0] req_all;
    logic [NUM_SRC:0]   lower_any;
    logic [NUM_SRC-1:0] grant;
    logic [6:0]         slot_acc [NUM_SRC+1];
    logic [6:0]         win_slot;
    logic               win_any;
    logic [23:0]        entry_addr;

    // Handshake qualifiers
    logic               ack_seen;
    logic               take_vec;

    // ************************************************************
    // Natural priority pick
    // ************************************************************
    assign req_all      = {irq_req_in, trap_req_in};
    assign lower_any[0] = 1'b0;
    assign slot_acc[0]  = 7'h00;

    // lowest slot wins
    // Ripple chain: slow but tiny, one cycle is plenty
    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_pick
            assign lower_any[g+1] = lower_any[g] | req_all[g];
            assign grant[g]       = req_all[g] & ~lower_any[g];
            assign slot_acc[g+1]  = slot_acc[g] | (grant[g] ? 7'(g) : 7'h00);
        end
    endgenerate

    // Only one grant is high, so OR-ing slot numbers is exact
    assign win_slot = slot_acc[NUM_SRC];
    assign win_any  = lower_any[NUM_SRC];

    // ************************************************************
    // Handshake qualifiers
    // ************************************************************
    // An ack counts only against a fetch that is really outstanding
    assign ack_seen = s_reg.fetch_req & fetch_ack_in;
    assign take_vec = win_any & s_reg.boot_done;

    // ************************************************************
    // Table address
    // ************************************************************
    // table select
    vector_addr_gen u_addr (
        .slot_in  (win_slot),
        .alt_in   (alt_table_select_in),
        .addr_out (entry_addr)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        s_next         = s_reg;
        // One-cycle pulse unless a load happens below
        s_next.pc_load = 1'b0;

        case (s_reg.state)
            ST_RESET_FETCH: begin
                // first fetch at zero
                // Ordinary fetch with no table involved
                s_next.fetch_req  = 1'b1;
                s_next.fetch_addr = vector_pkg::RESET_ADDR;
                if (ack_seen) begin
                    s_next.fetch_req = 1'b0;
                    s_next.boot_done = 1'b1;
                    s_next.ready     = 1'b1;
                    s_next.state     = ST_IDLE;
                end
            end

            ST_IDLE: begin
                // Requests outside idle are never taken
                if (take_vec) begin
                    s_next.fetch_req  = 1'b1;
                    s_next.fetch_addr = entry_addr;
                    s_next.vector_num = win_slot;
                    s_next.ready      = 1'b0;
                    s_next.state      = ST_VEC_FETCH;
                end
            end

            ST_VEC_FETCH: begin
                // Address held until ack; no timeout here
                if (ack_seen) begin
                    s_next.fetch_req = 1'b0;
                    s_next.pc        = fetch_data_in;
                    s_next.pc_load   = 1'b1;
                    s_next.ready     = 1'b1;
                    s_next.state     = ST_IDLE;
                end
            end

            default: begin
                s_next.state = ST_RESET_FETCH;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            // clear all, pc zero
            // A stray ack during reset is dropped
            s_reg.state      <= ST_RESET_FETCH;
            s_reg.fetch_req  <= 1'b0;
            s_reg.fetch_addr <= 24'h000000;
            s_reg.pc_load    <= 1'b0;
            s_reg.pc         <= 24'h000000;
            s_reg.vector_num <= 7'h00;
            s_reg.ready      <= 1'b0;
            s_reg.boot_done  <= 1'b0;
        end else if (clk_en_in) begin
            // Low enable also stretches a pending load pulse
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Straight from the state register, so no combinational path
    // reaches the core through this block
    assign fetch_req_out  = s_reg.fetch_req;
    assign fetch_addr_out = s_reg.fetch_addr;
    assign pc_load_out    = s_reg.pc_load;
    assign pc_out         = s_reg.pc;
    assign vector_num_out = s_reg.vector_num;
    assign ready_out      = s_reg.ready;
endmodule : reset_vector_unit

// File: reset_vector_unit_props.sv
// Purpose: Port assertions for the reset and vector unit.
// Assumes: Clock enable stays high while checked.
// Notes:   Bound after the module.
`timescale 1ns/1ps
module reset_vector_props #(parameter int IRQ_COUNT = 118) (
    input wire logic                 sys_clk_in, rst_b_in, clk_en_in, alt_table_select_in,
    input wire logic [7:0]           trap_req_in,
    input wire logic [IRQ_COUNT-1:0] irq_req_in,
    input wire logic                 fetch_req_out, fetch_ack_in, pc_load_out, ready_out,
    input wire logic [23:0]          fetch_addr_out, fetch_data_in, pc_out,
    input wire logic [6:0]           vector_num_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence vec_taken;
        $rose(fetch_req_out) && $past(ready_out);
    endsequence
    sequence entry_ack;
        fetch_ack_in && fetch_req_out;
    endsequence
    a_reset_clears: assert property (disable iff (1'b0) !rst_b_in |=>
        !fetch_req_out && pc_out == 24'h000000 && !ready_out) else $error("not cleared");
    a_boot_fetch_zero: assert property ($rose(rst_b_in) |=>
        fetch_req_out && fetch_addr_out == 24'h000000) else $error("boot fetch");
    a_boot_no_vector: assert property ($rose(rst_b_in) |=>
        fetch_addr_out == 24'h000000 until ready_out) else $error("early vector");
    a_boot_ready_bound: assert property ($rose(rst_b_in) |-> ##[1:20] ready_out)
        else $error("boot hang");
    a_boot_no_load: assert property (entry_ack and fetch_addr_out == 24'h000000 |=>
        !pc_load_out && pc_out == 24'h000000) else $error("boot load");
    a_entry_addr_map: assert property (vec_taken |-> fetch_addr_out == 24'h000004 +
        {16'h0000, vector_num_out, 1'b0} + ($past(alt_table_select_in) ? 24'h000100 : 24'h000000))
        else $error("entry address");
    a_pc_from_entry: assert property (entry_ack and fetch_addr_out != 24'h000000 |=>
        pc_load_out && pc_out == $past(fetch_data_in) ##1 !pc_load_out) else $error("pc load");
    a_trap_wins: assert property (ready_out && clk_en_in && |trap_req_in |=>
        vector_num_out < 7'h08) else $error("trap order");
    a_irq_zero_first: assert property (ready_out && clk_en_in && trap_req_in == 8'h00 &&
        irq_req_in[0] |=> vector_num_out == 7'h08) else $error("irq order");
endmodule : reset_vector_props
bind reset_vector_unit reset_vector_props #(.IRQ_COUNT(IRQ_COUNT)) i_props (.*);

// File: core_fetch_model.sv
// Purpose: Program memory side answering boot and vector fetches.
// Assumes: Ack after wait_in cycles, one cycle wide.
// Notes:   Data toggles whenever no answer is due.
`timescale 1ns/1ps
module core_fetch_model (
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic [23:0] addr_in,
    input  wire logic [3:0]  wait_in,
    output logic             ack_out,
    output logic      [23:0] data_out
);
    logic [3:0] cnt;
    initial begin
        ack_out = 1'b0;
        data_out = 24'h000000;
        cnt = 4'h0;
    end
    always @(posedge clk_in) begin
        #1;
        ack_out = req_in && !ack_out && cnt == wait_in;
        cnt = (req_in && !ack_out) ? cnt + 4'h1 : 4'h0;
        // every entry holds a handler address, unused ones too
        data_out = ack_out ? addr_in ^ 24'hA50000 : ~data_out;
    end
endmodule : core_fetch_model

// File: reset_and_vector_addressing_test.sv
// Purpose: Self-checking bench for boot and vector dispatch.
// Assumes: Handler address is entry address XOR A50000.
// Notes:   Clock enable held high throughout.
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
end
module reset_and_vector_addressing_test;
    logic         sys_clk_in = 0, rst_b_in = 0, clk_en_in = 1, alt_table_select_in = 0;
    logic         fetch_req_out, fetch_ack_in, pc_load_out, ready_out;
    logic [7:0]   trap_req_in = 8'h00;
    logic [117:0] irq_req_in = '0;
    logic [23:0]  fetch_addr_out, fetch_data_in, pc_out;
    logic [6:0]   vector_num_out;
    logic [3:0]   mem_wait = 4'h0;
    wire  [2:0]   flags = {ready_out, pc_load_out, fetch_req_out};
    int           fail_count = 0, num_checks = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    reset_vector_unit i_dut (.*);
    core_fetch_model i_mem (.clk_in(sys_clk_in), .req_in(fetch_req_out), .addr_in(fetch_addr_out),
        .wait_in(mem_wait), .ack_out(fetch_ack_in), .data_out(fetch_data_in));
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic step;
        @(posedge sys_clk_in);
        #1;
    endtask : step
    task automatic wait_for(int sel);
        for (int n = 0; n < 40 && flags[sel] !== 1'b1; n++) step;
    endtask : wait_for
    task automatic dispatch(logic [7:0] t, logic [117:0] q, logic a, logic [6:0] slot);
        logic [23:0] e;
        e = 24'h000004 + {16'h0000, slot, 1'b0} + (a ? 24'h000100 : 24'h000000);
        trap_req_in = t;
        irq_req_in = q;
        alt_table_select_in = a;
        wait_for(0);
        trap_req_in = 8'h00;
        irq_req_in = '0;
        `CHK("vector", slot, vector_num_out)
        `CHK("entry", e, fetch_addr_out)
        `CHK("busy", 1'b0, ready_out)
        wait_for(1);
        `CHK("pc", e ^ 24'hA50000, pc_out)
        `CHK("ready", 1'b1, ready_out)
    endtask : dispatch
    task automatic test_reset;
        rst_b_in = 1'b0;
        repeat (12) step;
        `CHK("pc in reset", 24'h000000, pc_out)
        irq_req_in[0] = 1'b1;
        mem_wait = 4'h3;
        rst_b_in = 1'b1;
        step;
        `CHK("boot fetch", 25'h1000000, {fetch_req_out, fetch_addr_out})
        wait_for(2);
        `CHK("pc after boot", 24'h000000, pc_out)
        dispatch(8'h00, 118'h1, 1'b0, 7'h08);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_priority;
        mem_wait = 4'h0;
        dispatch(8'h00, {1'b1, 111'h0, 6'h20}, 1'b0, 7'h0D);
        dispatch(8'h00, {1'b1, 117'h0}, 1'b0, 7'h7D);
        dispatch(8'h14, 118'h1, 1'b0, 7'h02);
        $display("test_priority done");
    endtask : test_priority
    task automatic test_alt;
        for (int t = 0; t < 8; t++) begin
            mem_wait = 4'(t);
            dispatch(8'h01 << t, '0, 1'b1, 7'(t));
        end
        dispatch(8'h00, {1'b1, 117'h0}, 1'b1, 7'h7D);
        $display("test_alt done");
    endtask : test_alt
    initial begin
        test_reset;
        test_priority;
        test_alt;
        // Second reset lands in mid-fetch
        trap_req_in = 8'h08;
        step;
        step;
        trap_req_in = 8'h00;
        test_reset;
        test_done;
    end
    initial begin
        #20000;
        fail_count++;
        test_done;
    end
endmodule : reset_and_vector_addressing_test
